//--- hdl/e1_tx_input.sv
`timescale 1ns/1ns
module e1_tx_input
  import e1_tx_pkg::*;
#(
  parameter int NCH = e1_tx_pkg::N_CH
)
(
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [e1_tx_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          global_driver_float,
  input  wire logic                          mclk_lost,
  input  wire logic [NCH-1:0]                tx_clock_in,
  input  wire logic [NCH-1:0]                tx_single_rail_data,
  input  wire logic [NCH-1:0]                tx_negative_rail_data,
  output logic      [NCH-1:0]                tx_line_pos,
  output logic      [NCH-1:0]                tx_line_neg,
  output logic      [NCH-1:0]                tx_line_pair_oe
);

  logic [CFG_W-1:0]     transmit_config_one [NCH];
  logic [1:0]           gfloat_sync;
  logic [1:0]           mclk_sync;
  logic                 soft_rst;
  logic [IDX_W-1:0]     idx;
  logic                 setup;
  logic                 wr_en;
  logic [NCH-1:0]       cfg_hit;
  logic                 hit_any;
  logic [31:0]          next_prdata;
  logic [NCH-1:0]       clk_lost;
  logic [NCH-1:0]       stb;
  logic [NCH-1:0]       smp_p;
  logic [NCH-1:0]       smp_n;
  logic [NCH-1:0]       next_oe;
  logic [PAT_CNT_W-1:0] pat_cnt;
  logic                 pat_stb;

  assign idx   = paddr[PADDR_W-1:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // ==========================================================================
  // Pin synchronisers for the asynchronous control inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gfloat_sync <= 2'h0;
      mclk_sync   <= 2'h0;
    end else if (clk_en) begin
      gfloat_sync <= {gfloat_sync[0], global_driver_float};
      mclk_sync   <= {mclk_sync[0], mclk_lost};
    end
  end

  // ==========================================================================
  // APB slave: data is prepared in the setup cycle so the first access cycle
  // completes; every transfer therefore takes exactly two cycles.
  always_comb begin
    hit_any = (idx == REG_GLOBAL_IDX) | (idx == REG_STATUS_IDX);
    for (int c = 0; c < NCH; c++) begin
      cfg_hit[c] = (idx == IDX_W'(REG_TX_CFG1_IDX + CH_STRIDE_IDX * c));
      hit_any    = hit_any | cfg_hit[c];
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (idx == REG_STATUS_IDX) begin
      next_prdata[STS_CLK_LOST +: NCH] = clk_lost;
      next_prdata[STS_OE +: NCH]       = tx_line_pair_oe;
      next_prdata[STS_MCLK_LOST]       = mclk_sync[1];
      next_prdata[STS_GLB_FLOAT]       = gfloat_sync[1];
    end
    for (int c = 0; c < NCH; c++) begin
      if (cfg_hit[c]) begin
        next_prdata[CFG_W-1:0] = transmit_config_one[c];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~hit_any;
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Soft reset: one-cycle pulse that returns configuration to its reset value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_rst <= 1'b0;
    end else if (clk_en) begin
      soft_rst <= wr_en & (idx == REG_GLOBAL_IDX) & pwdata[GLB_SOFT_RESET];
    end
  end

  // ==========================================================================
  // Per-channel configuration; reset value has the float bit set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        transmit_config_one[c] <= CFG_RESET;
      end
    end else if (clk_en) begin
      for (int c = 0; c < NCH; c++) begin
        if (soft_rst) begin
          transmit_config_one[c] <= CFG_RESET;
        end else if (wr_en && cfg_hit[c]) begin
          transmit_config_one[c] <= pwdata[CFG_W-1:0];
        end
      end
    end
  end

  // ==========================================================================
  // Internal pattern timing from the master clock, all ones at the E1 rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pat_cnt <= '0;
      pat_stb <= 1'b0;
    end else if (clk_en) begin
      if (pat_cnt == PAT_CNT_W'(PATTERN_DIV - 1)) begin
        pat_cnt <= '0;
        pat_stb <= 1'b1;
      end else begin
        pat_cnt <= pat_cnt + 1'b1;
        pat_stb <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Channels
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic cfg_inv;
      logic cfg_pat;
      logic bit_p;
      logic bit_n;
      logic bit_stb;

      assign cfg_inv = transmit_config_one[c][CFG_DATA_INV];
      assign cfg_pat = transmit_config_one[c][CFG_INT_PAT];
      // Negative rail is ignored in single rail, so a floating pin cannot leak
      assign bit_p   = cfg_pat | (smp_p[c] ^ cfg_inv);
      assign bit_n   = ~cfg_pat & transmit_config_one[c][CFG_DUAL_RAIL] &
                       (smp_n[c] ^ cfg_inv);
      assign bit_stb = cfg_pat ? pat_stb : stb[c];

      tclk_monitor u_mon (
        .clk          (clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .tx_clock_in  (tx_clock_in[c]),
        .data_p       (tx_single_rail_data[c]),
        .data_n       (tx_negative_rail_data[c]),
        .falling_edge (transmit_config_one[c][CFG_FALL_EDGE]),
        .sample_stb   (stb[c]),
        .sample_p     (smp_p[c]),
        .sample_n     (smp_n[c]),
        .clk_lost     (clk_lost[c])
      );

      line_encoder u_enc (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .bit_stb   (bit_stb),
        .bit_in    (bit_p),
        .neg_in    (bit_n),
        .dual_rail (transmit_config_one[c][CFG_DUAL_RAIL] & ~cfg_pat),
        .hdb3      (transmit_config_one[c][CFG_HDB3]),
        .line_pos  (tx_line_pos[c]),
        .line_neg  (tx_line_neg[c])
      );

      // Loopback and internal pattern do not depend on the transmit clock
      assign next_oe[c] = ~(gfloat_sync[1]
                          | mclk_sync[1]
                          | transmit_config_one[c][CFG_FLOAT]
                          | transmit_config_one[c][CFG_POWER_DOWN]
                          | soft_rst
                          | (clk_lost[c]
                             & ~transmit_config_one[c][CFG_REMOTE_LB]
                             & ~cfg_pat));
    end
  endgenerate

  // ==========================================================================
  // Driver enables start disabled, so the pair floats from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_line_pair_oe <= '0;
    end else if (clk_en) begin
      tx_line_pair_oe <= next_oe;
    end
  end

endmodule

//--- hdl/e1_tx_pkg.sv
package e1_tx_pkg;

  // ==========================================================================
  // Structure
  localparam int N_CH      = 2;
  localparam int PADDR_W   = 12;
  localparam int IDX_W     = 10;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] REG_GLOBAL_IDX   = 10'h000;
  localparam logic [IDX_W-1:0] REG_STATUS_IDX   = 10'h001;
  localparam logic [IDX_W-1:0] REG_TX_CFG1_IDX  = 10'h003;
  localparam logic [IDX_W-1:0] CH_STRIDE_IDX    = 10'h010;

  // ==========================================================================
  // Global register fields
  localparam int GLB_SOFT_RESET = 0;

  // ==========================================================================
  // transmit_config_one fields (one register per channel)
  localparam int CFG_W          = 8;
  localparam int CFG_FLOAT      = 0;
  localparam int CFG_POWER_DOWN = 1;
  localparam int CFG_DUAL_RAIL  = 2;
  localparam int CFG_HDB3       = 3;
  localparam int CFG_FALL_EDGE  = 4;
  localparam int CFG_DATA_INV   = 5;
  localparam int CFG_REMOTE_LB  = 6;
  localparam int CFG_INT_PAT    = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h01;

  // ==========================================================================
  // Status register fields
  localparam int STS_CLK_LOST = 0;
  localparam int STS_OE       = 2;
  localparam int STS_MCLK_LOST = 4;
  localparam int STS_GLB_FLOAT = 5;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int CLK_LOSS_LIMIT  = 70;
  localparam int LOSS_CNT_W      = 7;
  localparam int E1_BIT_NS       = 488;
  localparam int PATTERN_DIV     = (E1_BIT_NS / CLK_PERIOD_NS > 1) ?
                                   E1_BIT_NS / CLK_PERIOD_NS : 1;
  localparam int PAT_CNT_W       = 8;

  // ==========================================================================
  // Line symbols inside the encoder pipeline
  typedef enum logic [1:0] {
    SYM_ZERO = 2'b00,
    SYM_ONE  = 2'b01,
    SYM_B    = 2'b10,
    SYM_V    = 2'b11
  } sym_t;

endpackage

//--- hdl/tclk_monitor.sv
`timescale 1ns/1ns
module tclk_monitor
  import e1_tx_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic tx_clock_in,
  input  wire logic data_p,
  input  wire logic data_n,
  input  wire logic falling_edge,
  output logic      sample_stb,
  output logic      sample_p,
  output logic      sample_n,
  output logic      clk_lost
);

  logic [2:0]            clk_sync;
  logic [1:0]            p_sync;
  logic [1:0]            n_sync;
  logic [LOSS_CNT_W-1:0] still_cnt;
  logic                  rise;
  logic                  fall;

  // ==========================================================================
  // Synchronisers; data shares the clock's delay so the edge sees aligned bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync <= 3'h0;
      p_sync   <= 2'h0;
      n_sync   <= 2'h0;
    end else if (clk_en) begin
      clk_sync <= {clk_sync[1:0], tx_clock_in};
      p_sync   <= {p_sync[0], data_p};
      n_sync   <= {n_sync[0], data_n};
    end
  end

  assign rise = clk_sync[1] & ~clk_sync[2];
  assign fall = ~clk_sync[1] & clk_sync[2];

  // ==========================================================================
  // Sampling on the selected active edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_stb <= 1'b0;
      sample_p   <= 1'b0;
      sample_n   <= 1'b0;
    end else if (clk_en) begin
      sample_stb <= falling_edge ? fall : rise;
      if (falling_edge ? fall : rise) begin
        sample_p <= p_sync[1];
        sample_n <= n_sync[1];
      end
    end
  end

  // ==========================================================================
  // Loss detect: level held beyond the limit in master clock cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      still_cnt <= '0;
      clk_lost  <= 1'b0;
    end else if (clk_en) begin
      if (rise | fall) begin
        still_cnt <= '0;
        clk_lost  <= 1'b0;
      end else if (still_cnt != LOSS_CNT_W'(CLK_LOSS_LIMIT)) begin
        still_cnt <= still_cnt + 1'b1;
      end else begin
        clk_lost <= 1'b1;
      end
    end
  end

endmodule

//--- hdl/line_encoder.sv
`timescale 1ns/1ns
module line_encoder
  import e1_tx_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic bit_stb,
  input  wire logic bit_in,
  input  wire logic neg_in,
  input  wire logic dual_rail,
  input  wire logic hdb3,
  output logic      line_pos,
  output logic      line_neg
);

  sym_t pipe [4];
  logic last_pol;
  logic parity;
  logic run4;
  sym_t head;

  // Four zeros in a row once this one enters
  assign run4 = hdb3 & ~bit_in & (pipe[0] == SYM_ZERO) &
                (pipe[1] == SYM_ZERO) & (pipe[2] == SYM_ZERO);
  assign head = pipe[3];

  // ==========================================================================
  // Four-bit lookahead so a B pulse can be placed ahead of its V
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe[0]  <= SYM_ZERO;
      pipe[1]  <= SYM_ZERO;
      pipe[2]  <= SYM_ZERO;
      pipe[3]  <= SYM_ZERO;
      parity   <= 1'b0;
      last_pol <= 1'b0;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
    end else if (clk_en && bit_stb) begin
      if (dual_rail) begin
        // Both rails high is a space
        line_pos <= bit_in & ~neg_in;
        line_neg <= neg_in & ~bit_in;
      end else begin
        pipe[1] <= pipe[0];
        pipe[2] <= pipe[1];
        if (run4) begin
          pipe[0] <= SYM_V;
          pipe[3] <= parity ? SYM_ZERO : SYM_B;
          parity  <= 1'b0;
        end else begin
          pipe[0] <= bit_in ? SYM_ONE : SYM_ZERO;
          pipe[3] <= pipe[2];
          if (bit_in) begin
            parity <= ~parity;
          end
        end
        case (head)
          SYM_ONE, SYM_B: begin
            line_pos <= ~last_pol;
            line_neg <= last_pol;
            last_pol <= ~last_pol;
          end
          SYM_V: begin
            line_pos <= last_pol;
            line_neg <= ~last_pol;
          end
          default: begin
            line_pos <= 1'b0;
            line_neg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

//--- sim/e1_tx_input_monitor.sv
`timescale 1ns/1ns
module e1_tx_input_monitor
  import e1_tx_pkg::*;
#(
  parameter int NCH = N_CH
)
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic           global_driver_float,
  input wire logic           mclk_lost,
  input wire logic [NCH-1:0] tx_clock_in,
  input wire logic [NCH-1:0] tx_line_pos,
  input wire logic [NCH-1:0] tx_line_neg,
  input wire logic [NCH-1:0] tx_line_pair_oe
);
  // ==========================================================================
  // Cycles since each transmit clock last moved, saturating
  logic [NCH-1:0] prev_tclk;
  logic [7:0]     still [NCH];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_tclk <= '0;
      for (int c = 0; c < NCH; c++) still[c] <= 8'h00;
    end else begin
      prev_tclk <= tx_clock_in;
      for (int c = 0; c < NCH; c++)
        still[c] <= (tx_clock_in[c] != prev_tclk[c]) ? 8'h00 :
                    (still[c] == 8'hff) ? still[c] : still[c] + 8'h01;
    end
  end

  // ==========================================================================
  // Properties
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_ready_setup: assert property (s_setup |=> pready)
    else $error("ready missing in first access cycle");
  a_ready_only: assert property (pready |-> s_access)
    else $error("ready outside access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_pin_float: assert property (global_driver_float[*5] |-> tx_line_pair_oe == '0)
    else $error("drivers enabled under float pin");
  a_mclk_float: assert property (mclk_lost[*5] |-> tx_line_pair_oe == '0)
    else $error("drivers enabled with master clock lost");
  a_reset_float: assert property (!$past(rst_n) |-> (tx_line_pair_oe == '0) [*8])
    else $error("drivers enabled after reset");
  a_lost_rise: assert property ($rose(tx_line_pair_oe[0]) |-> still[0] < 8'd20)
    else $error("drivers enabled on a dead transmit clock");
  a_mark_excl: assert property ((tx_line_pos & tx_line_neg) == '0)
    else $error("both line rails marked");
endmodule

bind e1_tx_input e1_tx_input_monitor #(.NCH(NCH)) e1_tx_input_monitor_inst (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_driver_float(global_driver_float), .mclk_lost(mclk_lost),
  .tx_clock_in(tx_clock_in), .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg),
  .tx_line_pair_oe(tx_line_pair_oe)
);

//--- sim/e1_framer_model.sv
`timescale 1ns/1ns
module e1_framer_model (
  input  wire logic [1:0] run,
  input  wire logic       dual,
  input  wire logic       fe,
  input  wire logic [1:0] mode,
  output logic      [1:0] tx_clock_in,
  output logic      [1:0] tx_single_rail_data,
  output logic      [1:0] tx_negative_rail_data
);
  integer     seed = 52;
  logic [1:0] phase = 2'b00;
  initial begin
    tx_clock_in = 2'b00;
    tx_single_rail_data = 2'b00;
    tx_negative_rail_data = 2'b00;
  end
  // ==========================================================================
  // Offsets keep both clocks clear of the system clock edges and of each other
  for (genvar c = 0; c < 2; c++) begin : g_ch
    initial begin
      #(5 + 13 * c);
      forever begin
        #32;
        phase[c] = ~phase[c];
        if (run[c]) tx_clock_in[c] = phase[c];
        // Data moves on the inactive edge, far from the active one; it keeps
        // moving when the clock is stopped
        if (phase[c] == fe) begin
          tx_single_rail_data[c] = (mode == 2'd1) ? 1'b1 :
                                   (mode == 2'd2) ? 1'b0 : 1'($random(seed));
          tx_negative_rail_data[c] = dual ? 1'($random(seed)) : 1'b0;
        end
      end
    end
  end
endmodule

//--- sim/test_e1_tx_input.sv
`timescale 1ns/1ns
module test_e1_tx_input;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er, inv, lp, dual, fe;
  logic        global_driver_float, mclk_lost;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  tx_clock_in, tx_single_rail_data, tx_negative_rail_data, ep;
  logic [1:0]  tx_line_pos, tx_line_neg, tx_line_pair_oe, run, mode;
  int          bad_count, cmp_count, lchk, nb, zr, pm;
  logic        q [$];
  int          cfg_m [2];
  int          lost [2];

  e1_tx_input #(.NCH(2)) e1_tx_input_inst (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_driver_float(global_driver_float), .mclk_lost(mclk_lost),
    .tx_clock_in(tx_clock_in), .tx_single_rail_data(tx_single_rail_data),
    .tx_negative_rail_data(tx_negative_rail_data), .tx_line_pos(tx_line_pos),
    .tx_line_neg(tx_line_neg), .tx_line_pair_oe(tx_line_pair_oe));
  e1_framer_model e1_framer_model_inst (
    .run(run), .dual(dual), .fe(fe), .mode(mode), .tx_clock_in(tx_clock_in),
    .tx_single_rail_data(tx_single_rail_data),
    .tx_negative_rail_data(tx_negative_rail_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Checking and bus tasks
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    // Answer is taken at the same edge where pready is sampled high
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin chk(pready, 1'b1); stop_test(); end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == 12'h00c) cfg_m[0] = d;
    if (a == 12'h04c) cfg_m[1] = d;
    if (a == 12'h000 && d[0]) cfg_m = '{1, 1};
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(er, ee);
  endtask
  // Behavioural model of the driver enables
  task automatic cmp_oe(input int w);
    logic [1:0] e;
    repeat (w) @(posedge clk);
    @(negedge clk);
    for (int c = 0; c < 2; c++)
      e[c] = !(global_driver_float | mclk_lost | cfg_m[c][0] | cfg_m[c][1] |
               (lost[c] != 0 && !cfg_m[c][6] && !cfg_m[c][7]));
    chk(tx_line_pair_oe, e);
  endtask
  task automatic src(input int i, input logic v);
    case (i)
      0: begin @(posedge clk); global_driver_float <= v; end
      1: begin @(posedge clk); mclk_lost <= v; end
      2: wr(12'h00c, {31'h0, v});
      default: wr(12'h04c, {30'h0, v, 1'b0});
    endcase
  endtask
  task automatic line_run(input int k);
    nb = 0;
    pm = -1;
    lchk = k;
    repeat (400) @(posedge clk);
  endtask
  task automatic stop0(input logic s);
    @(posedge clk);
    run <= {1'b1, ~s};
  endtask

  // Line symbols seen at the active edge after the strobe that made them;
  // single rail adds four bits of lookahead, so the queue delays by five
  always @(tx_clock_in[0]) begin
    if (tx_clock_in[0] != fe) begin
      nb++;
      q.push_back(tx_single_rail_data[0]);
      if (q.size() > 6) void'(q.pop_front());
      zr = (tx_line_pos[0] | tx_line_neg[0]) ? 0 : zr + 1;
      if (nb > 8) begin
        case (lchk)
          1: chk({tx_line_pos[0], tx_line_neg[0]}, ep);
          2: chk((tx_line_pos[0] ^ tx_line_neg[0]) && tx_line_pos[0] != lp, 1);
          3: chk({tx_line_pos, tx_line_neg}, 0);
          4: chk(zr > 3, 0);
          5: begin
            chk(tx_line_pos[0] | tx_line_neg[0], q[0]);
            if (q[0] && pm >= 0) chk(tx_line_pos[0], pm == 0);
            if (tx_line_pos[0] | tx_line_neg[0]) pm = tx_line_pos[0];
          end
          default: ;
        endcase
      end
      lp = tx_line_pos[0];
      ep = inv ? {~tx_single_rail_data[0] & tx_negative_rail_data[0],
                  tx_single_rail_data[0] & ~tx_negative_rail_data[0]} :
                 {tx_single_rail_data[0] & ~tx_negative_rail_data[0],
                  tx_negative_rail_data[0] & ~tx_single_rail_data[0]};
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; global_driver_float = 1'b0; mclk_lost = 1'b0;
    run = 2'b11; dual = 1'b0; mode = 2'd0; inv = 1'b0; lchk = 0; nb = 0; zr = 0;
    fe = 1'b0; pm = -1;
    cfg_m = '{1, 1};
    lost = '{0, 0};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(12'h00c, 32'h1, 1'b0);
    rdchk(12'h04c, 32'h1, 1'b0);
    cmp_oe(2);
    rdchk(12'h100, 32'h0, 1'b1);
    wr(12'h00c, 32'h0);
    wr(12'h04c, 32'h0);
    cmp_oe(8);
    for (int i = 0; i < 4; i++) begin
      src(i, 1'b1);
      cmp_oe(8);
      src(i, 1'b0);
      cmp_oe(8);
    end
    stop0(1'b1);
    cmp_oe(52);
    lost[0] = 1;
    cmp_oe(30);
    stop0(1'b0);
    lost[0] = 0;
    cmp_oe(16);
    wr(12'h00c, 32'h40);
    stop0(1'b1);
    lost[0] = 1;
    cmp_oe(90);
    wr(12'h00c, 32'h80);
    cmp_oe(8);
    wr(12'h00c, 32'h0);
    cmp_oe(8);
    stop0(1'b0);
    lost[0] = 0;
    cmp_oe(16);
    wr(12'h00c, 32'h04);
    @(posedge clk);
    dual <= 1'b1;
    line_run(1);
    wr(12'h00c, 32'h24);
    inv = 1'b1;
    line_run(1);
    wr(12'h00c, 32'h34);
    fe <= 1'b1;
    line_run(1);
    wr(12'h00c, 32'h0);
    @(posedge clk);
    dual <= 1'b0;
    fe <= 1'b0;
    line_run(5);
    mode <= 2'd1;
    line_run(2);
    mode <= 2'd2;
    line_run(3);
    wr(12'h00c, 32'h08);
    line_run(4);
    lchk = 0;
    wr(12'h000, 32'h1);
    cmp_oe(8);
    rdchk(12'h00c, 32'h1, 1'b0);
    stop_test();
  end
endmodule
